// ===== accr_defines.svh
// register offsets, field positions, reset values and timing counts of the config bank
//
// Overview of operation
// - channel 2 code in bits 15:4, reset zero
// - control bit 13 enables channel 1 converter
// - bits 12:11 pick 4/8/16/32 sample average
// - control bit 0 starts one conversion, self-clears
// - result 10 bits left aligned in 15:6
// - ready flag resets 1, drops on start
// - config bit 15 makes window comparator latching
// - lock bit 14 blocks code, control and config writes; irq and trigger writes still land
// - unlock code then lock-bit zero write clears lock
// - unlock code is 0101 in bits 15:12
// - config bit 13 picks fault-dump row 0/1
// - config bit 12 enables internal reference
// - channel 1 power-down bits 11:10, reset 3
// - channel 0 power-down bits 8:7, reset 3
// - channel 2 bits 2:1, nonzero means powered down
`ifndef ACCR_DEFINES_SVH
`define ACCR_DEFINES_SVH

`define ACCR_ADDR_W          8
`define ACCR_OFF_CH2_CODE    8'h19
`define ACCR_OFF_CONV_CTRL   8'h1d
`define ACCR_OFF_CONV_RESULT 8'h1e
`define ACCR_OFF_SHARED_CFG  8'h1f
`define ACCR_OFF_TRIGGER     8'h20
`define ACCR_OFF_IRQ_STATUS  8'h40
`define ACCR_OFF_IRQ_MASK    8'h41

`define ACCR_RST_CH2_CODE    16'h0000
`define ACCR_RST_CONV_CTRL   16'h0000
`define ACCR_RST_SHARED_CFG  16'h0fff

`define ACCR_BIT_CONV_EN     13
`define ACCR_AVG_HI          12
`define ACCR_AVG_LO          11
`define ACCR_BIT_CONV_START  0
`define ACCR_CTRL_KEEP_MASK  16'hfffe
`define ACCR_BIT_WIN_LATCH   15
`define ACCR_BIT_LOCK        14
`define ACCR_BIT_ROW_SEL     13
`define ACCR_BIT_INT_REF     12
`define ACCR_PD1_HI          11
`define ACCR_PD1_LO          10
`define ACCR_PD0_HI          8
`define ACCR_PD0_LO          7
`define ACCR_PD2_HI          2
`define ACCR_PD2_LO          1
`define ACCR_CODE_HI         15
`define ACCR_CODE_LO         4
`define ACCR_RES_HI          15
`define ACCR_RES_LO          6
`define ACCR_UNLOCK_HI       15
`define ACCR_UNLOCK_LO       12
`define ACCR_UNLOCK_CODE     4'h5

// irq bits: 0 conversion done, 1 write refused by lock
`define ACCR_IRQ_DONE        0
`define ACCR_IRQ_REFUSED     1
`define ACCR_IRQ_W           2

// sample time per averaged sample, in ns
`define ACCR_SAMPLE_NS       1000
`define ACCR_CLK_NS          25
`define ACCR_SAMPLE_CYC      ((`ACCR_SAMPLE_NS + `ACCR_CLK_NS - 1) / `ACCR_CLK_NS)

`endif

// ===== accr_pkg.sv
// types shared by the config bank files
package accr_pkg;
    typedef logic [15:0] accr_word_t;
    typedef logic [7:0]  accr_addr_t;
    typedef enum logic [2:0] {
        ACCR_IDLE = 3'b001,
        ACCR_CONV = 3'b010,
        ACCR_DONE = 3'b100
    } accr_conv_e;
endpackage

// ===== accr_sequencer.sv
// conversion sequencer: counts averaged samples after a start pulse
`timescale 1ns/100ps
`include "accr_defines.svh"
module accr_sequencer
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic       enable,
    input  wire logic [1:0] avg_sel,
    input  wire logic [9:0] sample_in,
    output logic            busy,
    output logic            done,
    output logic [9:0]      result
);
    import accr_pkg::*;

    localparam int unsigned SAMPLE_CYC = `ACCR_SAMPLE_CYC;

    accr_conv_e  state;
    logic [5:0]  samples_left;
    logic [15:0] tick;
    logic [14:0] acc;

    assign busy = (state != ACCR_IDLE);

    // ======================================================
    // sequencing
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state        <= ACCR_IDLE;
            samples_left <= 6'h00;
            tick         <= 16'h0000;
            acc          <= 15'h0000;
            done         <= 1'b0;
            result       <= 10'h000;
        end else begin
            done <= 1'b0;
            unique case (state)
                ACCR_IDLE: begin
                    if (start && enable) begin
                        samples_left <= 6'(6'h04 << avg_sel);
                        tick         <= 16'(SAMPLE_CYC - 1);
                        acc          <= 15'h0000;
                        state        <= ACCR_CONV;
                    end
                end
                ACCR_CONV: begin
                    if (tick != 16'h0000) begin
                        tick <= tick - 16'h0001;
                    end else begin
                        acc          <= acc + {5'h00, sample_in};
                        samples_left <= samples_left - 6'h01;
                        tick         <= 16'(SAMPLE_CYC - 1);
                        if (samples_left == 6'h01) begin
                            state <= ACCR_DONE;
                        end
                    end
                end
                ACCR_DONE: begin
                    // divide by the sample count: shift by 2 plus avg_sel
                    result <= 10'((acc >> (3'd2 + {1'b0, avg_sel})));
                    done   <= 1'b1;
                    state  <= ACCR_IDLE;
                end
            endcase
        end
    end

    // ======================================================
    // checks
    a_done_from_seq: assert property (@(posedge clock) disable iff (!rst_n)
        done |-> $past(state) == ACCR_DONE) else $error("done without done state");
    a_start_needs_en: assert property (@(posedge clock) disable iff (!rst_n)
        (state == ACCR_IDLE && start && !enable) |=> state == ACCR_IDLE)
        else $error("conversion began while disabled");
endmodule

// ===== accr_config_bank.sv
// register bank of the three-channel front end: channel 2 code, converter control, shared config
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`include "accr_defines.svh"
module accr_config_bank
(
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire accr_pkg::accr_addr_t reg_addr,
    input  wire accr_pkg::accr_word_t reg_wdata,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    output accr_pkg::accr_word_t     reg_rdata,
    input  wire logic [9:0]          sample_in,
    output logic [11:0]              chan2_code,
    output logic                     conv_enable,
    output logic [1:0]               sample_average_select,
    output logic                     conv_busy,
    output logic                     result_valid_flag,
    output logic                     window_cmp_latching,
    output logic                     register_lock,
    output logic                     fault_dump_row_select,
    output logic                     int_ref_enable,
    output logic [1:0]               chan1_power_down_mode,
    output logic [1:0]               chan0_power_down_mode,
    output logic [1:0]               chan2_power_down_mode,
    output logic                     chan2_powered_down,
    output logic                     irq
);
    import accr_pkg::*;

    // ======================================================
    // storage
    accr_word_t ch2_code_reg;
    accr_word_t ctrl_reg;
    accr_word_t cfg_reg;
    logic       unlock_armed;
    logic       start_pulse;
    logic       seq_done;
    logic [9:0] seq_result;
    logic [9:0] result_data;
    logic [`ACCR_IRQ_W-1:0] irq_status;
    logic [`ACCR_IRQ_W-1:0] irq_mask;
    logic [`ACCR_IRQ_W-1:0] irq_event;

    logic wr_code;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_trig;
    logic lock_blocks;
    logic unlock_write;

    assign wr_code = reg_write && reg_addr == `ACCR_OFF_CH2_CODE;
    assign wr_ctrl = reg_write && reg_addr == `ACCR_OFF_CONV_CTRL;
    assign wr_cfg  = reg_write && reg_addr == `ACCR_OFF_SHARED_CFG;
    assign wr_trig = reg_write && reg_addr == `ACCR_OFF_TRIGGER;

    // a shared-config write of lock=0 after the unlock code is let through
    assign unlock_write = wr_cfg && unlock_armed && !reg_wdata[`ACCR_BIT_LOCK];
    // irq registers stay writable so a locked device can still be serviced
    assign lock_blocks  = register_lock && !unlock_write
                          && (wr_code || wr_ctrl || wr_cfg);

    // ======================================================
    // unlock sequence
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            unlock_armed <= 1'b0;
        end else if (wr_trig) begin
            // any other value in the field disarms
            unlock_armed <= reg_wdata[`ACCR_UNLOCK_HI:`ACCR_UNLOCK_LO]
                            == `ACCR_UNLOCK_CODE;
        end else if (wr_cfg) begin
            unlock_armed <= 1'b0;
        end
    end

    // ======================================================
    // channel 2 code
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ch2_code_reg <= `ACCR_RST_CH2_CODE;
        end else if (wr_code && !register_lock) begin
            // low nibble is ignored
            ch2_code_reg <= {reg_wdata[`ACCR_CODE_HI:`ACCR_CODE_LO], 4'h0};
        end
    end

    // ======================================================
    // converter control
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg    <= `ACCR_RST_CONV_CTRL;
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= wr_ctrl && !register_lock
                           && reg_wdata[`ACCR_BIT_CONV_START];
            if (wr_ctrl && !register_lock) begin
                // start bit never stored: it reads back zero
                ctrl_reg <= reg_wdata & `ACCR_CTRL_KEEP_MASK;
            end
        end
    end

    // ======================================================
    // shared configuration
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_reg <= `ACCR_RST_SHARED_CFG;
        end else if (wr_cfg && (!register_lock || unlock_write)) begin
            cfg_reg <= reg_wdata;
        end
    end

    // ======================================================
    // conversion result and ready flag
    accr_sequencer u_seq (
        .clock     (clock),
        .rst_n     (rst_n),
        .start     (start_pulse),
        .enable    (conv_enable),
        .avg_sel   (sample_average_select),
        .sample_in (sample_in),
        .busy      (conv_busy),
        .done      (seq_done),
        .result    (seq_result)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            result_valid_flag <= 1'b1;
            result_data       <= 10'h000;
        end else if (seq_done) begin
            result_valid_flag <= 1'b1;
            result_data       <= seq_result;
        end else if (start_pulse && conv_enable) begin
            result_valid_flag <= 1'b0;
        end
    end

    // ======================================================
    // interrupts
    assign irq_event = {lock_blocks, seq_done};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_status <= '0;
            irq_mask   <= '0;
        end else begin
            // a new event wins over a write-one clear in the same cycle
            if (reg_write && reg_addr == `ACCR_OFF_IRQ_STATUS) begin
                irq_status <= (irq_status & ~reg_wdata[`ACCR_IRQ_W-1:0]) | irq_event;
            end else begin
                irq_status <= irq_status | irq_event;
            end
            if (reg_write && reg_addr == `ACCR_OFF_IRQ_MASK) begin
                irq_mask <= reg_wdata[`ACCR_IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ======================================================
    // field outputs to the analog core
    assign chan2_code            = ch2_code_reg[`ACCR_CODE_HI:`ACCR_CODE_LO];
    assign conv_enable           = ctrl_reg[`ACCR_BIT_CONV_EN];
    assign sample_average_select = ctrl_reg[`ACCR_AVG_HI:`ACCR_AVG_LO];
    assign window_cmp_latching   = cfg_reg[`ACCR_BIT_WIN_LATCH];
    assign register_lock         = cfg_reg[`ACCR_BIT_LOCK];
    assign fault_dump_row_select = cfg_reg[`ACCR_BIT_ROW_SEL];
    assign int_ref_enable        = cfg_reg[`ACCR_BIT_INT_REF];
    assign chan1_power_down_mode = cfg_reg[`ACCR_PD1_HI:`ACCR_PD1_LO];
    assign chan0_power_down_mode = cfg_reg[`ACCR_PD0_HI:`ACCR_PD0_LO];
    assign chan2_power_down_mode = cfg_reg[`ACCR_PD2_HI:`ACCR_PD2_LO];
    assign chan2_powered_down    = chan2_power_down_mode != 2'b00;

    // ======================================================
    // read port: data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            unique case (reg_addr)
                `ACCR_OFF_CH2_CODE:    reg_rdata <= ch2_code_reg;
                `ACCR_OFF_CONV_CTRL:   reg_rdata <= ctrl_reg;
                `ACCR_OFF_CONV_RESULT: reg_rdata <= {result_data, 5'h00,
                                                     result_valid_flag};
                `ACCR_OFF_SHARED_CFG:  reg_rdata <= cfg_reg;
                `ACCR_OFF_IRQ_STATUS:  reg_rdata <= {14'h0000, irq_status};
                `ACCR_OFF_IRQ_MASK:    reg_rdata <= {14'h0000, irq_mask};
                default:               reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ======================================================
    // checks
    a_code_write_lands: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_code && !register_lock) |=> chan2_code == $past(reg_wdata[15:4]))
        else $error("code write lost");
    a_lock_holds_code: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_code && register_lock) |=> $stable(chan2_code))
        else $error("locked code changed");
    a_start_self_clr: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_ctrl && !register_lock) |=> ctrl_reg == ($past(reg_wdata) & 16'hfffe))
        else $error("control write stored wrongly");
    a_ready_drops: assert property (@(posedge clock) disable iff (!rst_n)
        (start_pulse && conv_enable && !seq_done) |=> !result_valid_flag)
        else $error("ready flag did not drop");
    a_ready_returns: assert property (@(posedge clock) disable iff (!rst_n)
        seq_done |=> result_valid_flag) else $error("ready flag not restored");
    a_unlock_order: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_trig && reg_wdata[15:12] == 4'h5 && register_lock) ##1
        (wr_cfg && !reg_wdata[14]) |=> !register_lock)
        else $error("unlock sequence refused");
    a_bad_code_keeps: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_trig && reg_wdata[15:12] != 4'h5 && register_lock) ##1
        (wr_cfg && !reg_wdata[14]) |=> register_lock)
        else $error("wrong code unlocked");
    a_ch2_pd_map: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_cfg && !register_lock) |=> chan2_powered_down == ($past(reg_wdata[2:1]) != 2'b00))
        else $error("channel 2 power state wrong");
    a_read_latency: assert property (@(posedge clock) disable iff (!rst_n)
        (reg_read && reg_addr == 8'h1f) |=> reg_rdata == $past(cfg_reg))
        else $error("config readback wrong");
    a_row_select: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_cfg && !register_lock) |=> fault_dump_row_select == $past(reg_wdata[13]))
        else $error("row select not updated");

    c_conversion: cover property (@(posedge clock) disable iff (!rst_n) seq_done);
    c_unlock: cover property (@(posedge clock) disable iff (!rst_n)
        register_lock ##1 !register_lock);
    c_refused: cover property (@(posedge clock) disable iff (!rst_n) lock_blocks);
    c_irq: cover property (@(posedge clock) disable iff (!rst_n) irq);
endmodule

// ===== accr_config_bank_tb.sv
// self-checking bench for the config bank: bus tasks and register scenarios
`timescale 1ns/100ps
`include "accr_defines.svh"
module accr_config_bank_tb;
    import accr_pkg::*;

    // ==========================================================
    // stimulus and observed signals
    logic        clock     = 1'b0;
    logic        rst_n     = 1'b0;
    accr_addr_t  reg_addr  = 8'h00;
    accr_word_t  reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read  = 1'b0;
    logic [9:0]  sample_in = 10'h2a5;
    accr_word_t  reg_rdata;
    logic [11:0] chan2_code;
    logic        conv_enable;
    logic [1:0]  sample_average_select;
    logic        conv_busy;
    logic        result_valid_flag;
    logic        window_cmp_latching;
    logic        register_lock;
    logic        fault_dump_row_select;
    logic        int_ref_enable;
    logic [1:0]  chan1_power_down_mode;
    logic [1:0]  chan0_power_down_mode;
    logic [1:0]  chan2_power_down_mode;
    logic        chan2_powered_down;
    logic        irq;
    int          n_errors  = 0;
    int          tests_run = 0;
    int          cyc       = 0;

    always #12.5 clock = ~clock;

    accr_config_bank DUT (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .sample_in(sample_in), .chan2_code(chan2_code), .conv_enable(conv_enable),
        .sample_average_select(sample_average_select), .conv_busy(conv_busy),
        .result_valid_flag(result_valid_flag), .window_cmp_latching(window_cmp_latching),
        .register_lock(register_lock), .fault_dump_row_select(fault_dump_row_select),
        .int_ref_enable(int_ref_enable), .chan1_power_down_mode(chan1_power_down_mode),
        .chan0_power_down_mode(chan0_power_down_mode),
        .chan2_power_down_mode(chan2_power_down_mode),
        .chan2_powered_down(chan2_powered_down), .irq(irq)
    );

    // ==========================================================
    // bus tasks; each returns 1 ns after a clock edge so outputs have settled
    task automatic chk(input accr_word_t seen, input accr_word_t exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input accr_addr_t a, input accr_word_t d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask

    // two writes with no gap between the strobes
    task automatic wr2(input accr_addr_t a0, input accr_word_t d0,
                       input accr_addr_t a1, input accr_word_t d1);
        @(posedge clock);
        reg_addr  <= a0;
        reg_wdata <= d0;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_addr  <= a1;
        reg_wdata <= d1;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd(input accr_addr_t a, output accr_word_t d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rchk(input accr_addr_t a, input accr_word_t e);
        accr_word_t v;
        rd(a, v);
        chk(v, e);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one conversion; the sample value is held still so the average is exact
    task automatic convert(input logic [1:0] avg, input logic [9:0] val);
        int n;
        int lim;
        @(posedge clock);
        sample_in <= val;
        wr(`ACCR_OFF_CONV_CTRL, {3'b001, avg, 10'h1e0, 1'b1});
        chk(conv_enable, 1'b1);
        chk(sample_average_select, avg);
        @(posedge clock);
        #1;
        chk(result_valid_flag, 1'b0);
        chk(conv_busy, 1'b1);
        lim = (4 << avg) * `ACCR_SAMPLE_CYC;
        n = 1;
        while (result_valid_flag !== 1'b1 && n < 3000) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk(n >= lim - 2 && n <= lim + 8, 1'b1);
        rchk(`ACCR_OFF_CONV_RESULT, {val, 5'h00, 1'b1});
        rchk(`ACCR_OFF_CONV_CTRL, {3'b001, avg, 10'h1e0, 1'b0});
    endtask

    // ==========================================================
    // hang guard: longest path is four conversions plus about fifty accesses
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        accr_word_t w;
        logic [1:0] p;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);

        rchk(`ACCR_OFF_CH2_CODE, 16'h0000);
        rchk(`ACCR_OFF_CONV_CTRL, 16'h0000);
        rchk(`ACCR_OFF_CONV_RESULT, 16'h0001);
        rchk(`ACCR_OFF_SHARED_CFG, 16'h0fff);
        chk({chan1_power_down_mode, chan0_power_down_mode}, 4'hf);
        chk({chan2_powered_down, register_lock, irq}, 3'b100);
        $display("test reset values done");

        wr(`ACCR_OFF_CH2_CODE, 16'h5a5f);
        chk(chan2_code, 12'h5a5);
        rd(`ACCR_OFF_CH2_CODE, w);
        chk(w & 16'hfff0, 16'h5a50);
        $display("test channel 2 code done");

        // all four encodings of every two-bit field, plus the three single-bit selects
        for (int i = 0; i < 4; i++) begin
            p = i[1:0];
            w = {p[1], 1'b0, p[0], p[1], p, 1'b1, p, 4'hf, p, 1'b1};
            wr(`ACCR_OFF_SHARED_CFG, w);
            chk(window_cmp_latching, p[1]);
            chk(fault_dump_row_select, p[0]);
            chk(int_ref_enable, p[1]);
            chk(chan1_power_down_mode, p);
            chk(chan0_power_down_mode, p);
            chk(chan2_power_down_mode, p);
            chk(chan2_powered_down, p != 2'b00);
            rchk(`ACCR_OFF_SHARED_CFG, w);
        end
        $display("test shared configuration done");

        for (int a = 0; a < 4; a++) begin
            convert(a[1:0], 10'h2a5 + 10'(a * 83));
        end
        // a start with the converter disabled leaves flag and sequencer idle
        wr(`ACCR_OFF_CONV_CTRL, {3'b000, 2'b00, 10'h1e0, 1'b1});
        @(posedge clock);
        #1;
        chk(result_valid_flag, 1'b1);
        chk(conv_busy, 1'b0);
        $display("test conversions done");

        rchk(`ACCR_OFF_IRQ_STATUS, 16'h0001);
        chk(irq, 1'b0);
        wr(`ACCR_OFF_IRQ_MASK, 16'h0003);
        chk(irq, 1'b1);
        wr(`ACCR_OFF_IRQ_STATUS, 16'h0001);
        chk(irq, 1'b0);
        rchk(`ACCR_OFF_IRQ_STATUS, 16'h0000);
        $display("test interrupt done");

        wr(`ACCR_OFF_SHARED_CFG, 16'h4fff);
        chk(register_lock, 1'b1);
        wr(`ACCR_OFF_CH2_CODE, 16'h1230);
        chk(chan2_code, 12'h5a5);
        chk(irq, 1'b1);
        rchk(`ACCR_OFF_IRQ_STATUS, 16'h0002);
        wr(`ACCR_OFF_IRQ_STATUS, 16'h0002);
        chk(irq, 1'b0);
        wr(`ACCR_OFF_SHARED_CFG, 16'h0fff);
        chk(register_lock, 1'b1);
        // a wrong code must not arm the release
        wr(`ACCR_OFF_TRIGGER, 16'h3000);
        wr(`ACCR_OFF_SHARED_CFG, 16'h0fff);
        chk(register_lock, 1'b1);
        wr(`ACCR_OFF_TRIGGER, 16'h5000);
        wr(`ACCR_OFF_SHARED_CFG, 16'h0fff);
        chk(register_lock, 1'b0);
        wr(`ACCR_OFF_CH2_CODE, 16'h1230);
        chk(chan2_code, 12'h123);
        // same release order again, with the strobes back to back
        wr(`ACCR_OFF_SHARED_CFG, 16'h4fff);
        chk(register_lock, 1'b1);
        wr2(`ACCR_OFF_TRIGGER, 16'h6000, `ACCR_OFF_SHARED_CFG, 16'h0fff);
        chk(register_lock, 1'b1);
        wr2(`ACCR_OFF_TRIGGER, 16'h5000, `ACCR_OFF_SHARED_CFG, 16'h0fff);
        chk(register_lock, 1'b0);
        $display("test lock done");

        wr(8'h33, 16'hffff);
        rchk(8'h33, 16'h0000);
        rchk(`ACCR_OFF_TRIGGER, 16'h0000);
        $display("test unmapped done");

        tally_and_finish();
    end
endmodule
